// ---- src/cars_pkg.sv ----
package cars_pkg;

	// ****************************************************************
	// Register file geometry
	// ****************************************************************
	localparam int unsigned XLEN = 64; // Width of every integer register
	localparam int unsigned NREG = 32; // Number of integer registers
	localparam int unsigned IDX_W = 5; // Width of a register specifier
	localparam logic [4:0] SP_IDX = 5'h1e; // Stack pointer entry
	localparam logic [4:0] ZERO_IDX = 5'h1f; // Hard-wired zero entry (integer and float)
	localparam logic [63:0] ZERO_WORD = 64'h0000_0000_0000_0000;

	// ****************************************************************
	// Program counter
	// ****************************************************************
	localparam int unsigned PC_W = 62; // Stored bits <63:2>
	localparam logic [61:0] PC_RESET = 62'h0000_0000_0000_0000; // Word index after reset
	localparam logic [61:0] PC_STEP = 62'h0000_0000_0000_0001; // One longword per instruction
	localparam logic [1:0] PC_LOW = 2'h0; // Low bits always read as zero

	// ****************************************************************
	// Processor status
	// ****************************************************************
	localparam int unsigned STAT_W = 16; // Whole status word
	localparam int unsigned STAT_SW_LSB = 0; // Software field position
	localparam int unsigned STAT_SW_W = 2; // Software field width
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [15:0] STAT_SW_MASK = 16'h0003; // Bits a privileged write may change

	// ****************************************************************
	// Stack and alignment
	// ****************************************************************
	localparam int unsigned SP_LEN_W = 8; // Width of the byte count of one push or pop
	localparam logic [2:0] LONG_MASK = 3'h3; // Low 2 bits must be zero
	localparam logic [2:0] QUAD_MASK = 3'h7; // Low 3 bits must be zero

	// Operand data types seen by the pipeline
	typedef enum logic [3:0] {
		DT_LONG = 4'h0,
		DT_QUAD = 4'h1,
		DT_FFLT = 4'h2,
		DT_GFLT = 4'h3,
		DT_DFLT = 4'h4,
		DT_SFLT = 4'h5,
		DT_TFLT = 4'h6,
		DT_OCTA = 4'h7,
		DT_HFLT = 4'h8,
		DT_BITF = 4'h9,
		DT_CHAR = 4'ha,
		DT_TNUM = 4'hb,
		DT_LNUM = 4'hc,
		DT_PACK = 4'hd
	} cars_dtype_t;

	// Kind of operation applied to the operand
	typedef enum logic [1:0] {
		OP_LOAD = 2'h0,
		OP_STORE = 2'h1,
		OP_CVTG = 2'h2,
		OP_ARITH = 2'h3
	} cars_opkind_t;

endpackage

// ---- src/cars_core.sv ----
// Summary of operation
// RULE1: Decode advances program counter one instruction
// RULE2: Consumers get the updated program counter
// RULE3: Counter keeps bits 63:2; low bits zero
// RULE4: Counter is implicit branch and jump operand
// RULE5: No register specifier reaches the counter
// RULE6: Thirty-two integer registers, 64 bits each
// RULE7: Register thirty is the stack pointer
// RULE8: Unsigned predecrement push, postincrement pop
// RULE9: Register thirty-one reads as zero
// RULE10: Writes to register thirty-one are discarded
// RULE11: Status readable; only software field writable
// RULE12: Longword and single floats need 2-bit alignment
// RULE13: Quadword and double floats need 3-bit alignment
// RULE14: Unsupported data types flagged; D only moves
// RULE15: Float register thirty-one reads zero, drops writes
// RULE16: Written values visible to later reads
`timescale 1ns/1ps
`default_nettype none

module cars_core (
	input wire logic clk,
	input wire logic sys_rst,
	// Instruction decode and redirect
	input wire logic decode_valid,
	input wire logic redirect_valid,
	input wire logic [63:0] redirect_addr,
	output logic [63:0] updated_pc,
	// Integer read ports
	input wire logic [cars_pkg::IDX_W-1:0] rd_a_idx,
	output logic [63:0] rd_a_data,
	input wire logic [cars_pkg::IDX_W-1:0] rd_b_idx,
	output logic [63:0] rd_b_data,
	// Integer write port
	input wire logic wr_en,
	input wire logic [cars_pkg::IDX_W-1:0] wr_idx,
	input wire logic [63:0] wr_data,
	// Implicit stack operations
	input wire logic sp_push,
	input wire logic sp_pop,
	input wire logic [cars_pkg::SP_LEN_W-1:0] sp_len,
	output logic [63:0] sp_addr,
	// Processor status
	input wire logic priv_mode,
	input wire logic read_status_call,
	input wire logic write_status_call,
	input wire logic [cars_pkg::STAT_SW_W-1:0] status_sw_data,
	input wire logic hw_status_load,
	input wire logic [cars_pkg::STAT_W-1:0] hw_status_data,
	output logic [cars_pkg::STAT_W-1:0] status_rd_data,
	// Float zero filter
	input wire logic [cars_pkg::IDX_W-1:0] fp_rd_idx,
	input wire logic [63:0] fp_rd_raw,
	output logic [63:0] fp_rd_data,
	input wire logic fp_wr_en_in,
	input wire logic [cars_pkg::IDX_W-1:0] fp_wr_idx,
	output logic fp_wr_en_out,
	// Operand classification
	input wire logic [2:0] oper_addr_low,
	input wire cars_pkg::cars_dtype_t oper_type,
	input wire cars_pkg::cars_opkind_t oper_kind,
	output logic oper_misaligned,
	output logic oper_unsupported
);
	import cars_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [NREG-1:0][XLEN-1:0] regs; // Integer register array RULE6
		logic [PC_W-1:0] pc; // Program counter bits <63:2>
		logic [STAT_W-1:0] stat; // Processor status word
		logic [63:0] rd_a; // Registered read data A
		logic [63:0] rd_b; // Registered read data B
		logic [63:0] sp_addr; // Address of the pushed or popped item
		logic [63:0] fp_rd; // Filtered float read data
		logic [STAT_W-1:0] stat_rd; // Status read result
		logic misal; // Alignment verdict
		logic unsup; // Unsupported data type verdict
	} cars_state_t;

	cars_state_t state_q; // Registered state
	cars_state_t state_d; // Next state

	// Required alignment mask for a data type
	function automatic logic [2:0] align_mask(input cars_dtype_t t);
		case (t)
			DT_LONG, DT_FFLT, DT_SFLT: align_mask = LONG_MASK; // RULE12
			DT_QUAD, DT_GFLT, DT_DFLT, DT_TFLT: align_mask = QUAD_MASK; // RULE13
			default: align_mask = 3'h0;
		endcase
	endfunction

	// Register read with the zero entry forced
	function automatic logic [63:0] reg_read(input logic [NREG-1:0][XLEN-1:0] r, input logic [4:0] i);
		if (i == ZERO_IDX) begin
			reg_read = ZERO_WORD; // RULE9
		end else begin
			reg_read = r[i];
		end
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// All updates are computed first, then reads sample the updated
	// array, so a same-cycle write is forwarded without a bypass mux.
	always_comb begin
		state_d = state_q;
		// Redirect outranks sequential advance
		if (redirect_valid) begin
			state_d.pc = redirect_addr[63:2]; // RULE3 RULE4
		end else if (decode_valid) begin
			state_d.pc = state_q.pc + PC_STEP; // RULE1
		end
		// Explicit write; register thirty-one never stores anything
		if (wr_en && (wr_idx != ZERO_IDX)) begin
			state_d.regs[wr_idx] = wr_data; // RULE10 RULE16
		end
		// Stack operations take the written value and win over it
		if (sp_push) begin
			state_d.regs[SP_IDX] = state_d.regs[SP_IDX] - {56'h0000_0000_0000_00, sp_len}; // RULE7 RULE8
			state_d.sp_addr = state_d.regs[SP_IDX]; // RULE8
		end else if (sp_pop) begin
			state_d.sp_addr = state_d.regs[SP_IDX]; // RULE8
			state_d.regs[SP_IDX] = state_d.regs[SP_IDX] + {56'h0000_0000_0000_00, sp_len}; // RULE8
		end
		state_d.regs[ZERO_IDX] = ZERO_WORD; // RULE9
		// Reads index the integer array only; the counter is not in it
		state_d.rd_a = reg_read(state_d.regs, rd_a_idx); // RULE5 RULE16
		state_d.rd_b = reg_read(state_d.regs, rd_b_idx); // RULE5 RULE16
		// Hardware status load first, software field write on top
		if (hw_status_load) begin
			state_d.stat = hw_status_data;
		end
		if (write_status_call && priv_mode) begin
			state_d.stat = (state_d.stat & ~STAT_SW_MASK) |
				(STAT_SW_MASK & (STAT_W'(status_sw_data) << STAT_SW_LSB)); // RULE11
		end
		if (read_status_call && priv_mode) begin
			state_d.stat_rd = state_q.stat; // RULE11
		end
		// Float zero entry
		state_d.fp_rd = (fp_rd_idx == ZERO_IDX) ? ZERO_WORD : fp_rd_raw; // RULE15
		// Operand checks
		state_d.misal = (oper_addr_low & align_mask(oper_type)) != 3'h0; // RULE12 RULE13
		case (oper_type)
			DT_OCTA, DT_HFLT, DT_BITF, DT_CHAR, DT_TNUM, DT_LNUM, DT_PACK: begin
				state_d.unsup = 1'b1; // RULE14
			end
			DT_DFLT: begin
				state_d.unsup = (oper_kind == OP_ARITH); // RULE14
			end
			default: begin
				state_d.unsup = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Synchronous reset; the array is cleared so reads are defined
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= '0;
			state_q.pc <= PC_RESET;
			state_q.stat <= STAT_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign updated_pc = {state_q.pc, PC_LOW}; // RULE2 RULE3
	assign rd_a_data = state_q.rd_a;
	assign rd_b_data = state_q.rd_b;
	assign sp_addr = state_q.sp_addr;
	assign status_rd_data = state_q.stat_rd;
	assign fp_rd_data = state_q.fp_rd;
	// Handshake-like strobe, combinational on purpose
	assign fp_wr_en_out = fp_wr_en_in && (fp_wr_idx != ZERO_IDX); // RULE15
	assign oper_misaligned = state_q.misal;
	assign oper_unsupported = state_q.unsup;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_pc_advance: assert property (decode_valid && !redirect_valid |=> updated_pc == $past(updated_pc) + 64'h0000_0000_0000_0004) // RULE1
		else $error("pc did not advance by one instruction");
	chk_pc_redirect: assert property (redirect_valid |=> updated_pc == {$past(redirect_addr[63:2]), PC_LOW}) // RULE3
		else $error("pc did not take the redirect target");
	chk_pc_low: assert property (updated_pc[1:0] == PC_LOW) // RULE3
		else $error("pc low bits not zero");
	chk_zero_read: assert property (rd_a_idx == ZERO_IDX ##1 1'b1 |-> rd_a_data == ZERO_WORD) // RULE9
		else $error("zero register read nonzero");
	chk_write_visible: assert property (wr_en && wr_idx != ZERO_IDX && !(wr_idx == SP_IDX && (sp_push || sp_pop)) // RULE16
		&& rd_b_idx == wr_idx |=> rd_b_data == $past(wr_data))
		else $error("written value not visible");
	// After a push the reported address is the new, lowered pointer
	chk_push_pre: assert property (sp_push && !wr_en |=> sp_addr == state_q.regs[SP_IDX] // RULE8
		&& state_q.regs[SP_IDX] == $past(state_q.regs[SP_IDX]) - {56'h0000_0000_0000_00, $past(sp_len)})
		else $error("push did not predecrement");
	chk_pop_post: assert property (sp_pop && !sp_push && !wr_en |=> sp_addr == $past(state_q.regs[SP_IDX]) // RULE8
		&& state_q.regs[SP_IDX] == $past(state_q.regs[SP_IDX]) + {56'h0000_0000_0000_00, $past(sp_len)})
		else $error("pop did not postincrement");
	chk_stat_guard: assert property (!hw_status_load && !(write_status_call && priv_mode) // RULE11
		|=> state_q.stat == $past(state_q.stat))
		else $error("status changed without a write");
	chk_stat_hw_bits: assert property (!hw_status_load // RULE11
		|=> (state_q.stat & ~STAT_SW_MASK) == ($past(state_q.stat) & ~STAT_SW_MASK))
		else $error("status non-software bits written");
	chk_align_quad: assert property (oper_type == DT_QUAD |=> oper_misaligned == ($past(oper_addr_low) != 3'h0)) // RULE13
		else $error("quadword alignment verdict wrong");
	chk_align_long: assert property (oper_type == DT_SFLT |=> oper_misaligned == ($past(oper_addr_low[1:0]) != 2'h0)) // RULE12
		else $error("longword alignment verdict wrong");
	chk_dflt_move: assert property (oper_type == DT_DFLT |=> oper_unsupported == ($past(oper_kind) == OP_ARITH)) // RULE14
		else $error("double-d support verdict wrong");
	chk_fp_zero: assert property (fp_rd_idx == ZERO_IDX |=> fp_rd_data == ZERO_WORD) // RULE15
		else $error("float zero register read nonzero");

	cov_push_pop: cover property (sp_push ##1 sp_pop);
	cov_redirect: cover property (decode_valid ##1 redirect_valid);
	cov_fwd: cover property (wr_en && rd_a_idx == wr_idx && wr_idx != ZERO_IDX);
	cov_stat_write: cover property (write_status_call && priv_mode);

endmodule

`default_nettype wire

// ---- testbench/cars_pipe_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Far-side pipeline: floating register file read path
// ****************************************************************
module cars_pipe_model (
	input wire logic [4:0] fp_rd_idx,
	output logic [63:0] fp_rd_raw
);
	// Raw float word is never zero, so a missing zero filter shows up
	assign fp_rd_raw = 64'h3ff0_0000_0000_0000 | {59'h0, fp_rd_idx};
endmodule
`default_nettype wire

// ---- testbench/cpu_arch_register_state_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_arch_register_state_bench;
	import cars_pkg::*;
	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	logic clk = 1'b0, sys_rst = 1'b1, decode_valid = 1'b0, redirect_valid = 1'b0, wr_en = 1'b0;
	logic sp_push = 1'b0, sp_pop = 1'b0, priv_mode = 1'b0, read_status_call = 1'b0;
	logic write_status_call = 1'b0, hw_status_load = 1'b0, fp_wr_en_in = 1'b0;
	logic [63:0] redirect_addr = '0, wr_data = '0, updated_pc, rd_a_data, rd_b_data, sp_addr, fp_rd_raw, fp_rd_data;
	logic [4:0] rd_a_idx = '0, rd_b_idx = '0, wr_idx = '0, fp_rd_idx = '0, fp_wr_idx = '0;
	logic [7:0] sp_len = '0;
	logic [1:0] status_sw_data = '0;
	logic [15:0] hw_status_data = '0, status_rd_data;
	logic [2:0] oper_addr_low = '0;
	logic fp_wr_en_out, oper_misaligned, oper_unsupported;
	cars_dtype_t oper_type = DT_LONG;
	cars_opkind_t oper_kind = OP_LOAD;
	int fails = 0, n_checks = 0;
	cars_core DUT (.*);
	cars_pipe_model PIPE (.*);
	// Free-running core clock
	always #2 clk = ~clk;
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Distinct word per register, so an aliased index cannot hide
	function automatic logic [63:0] pat(input int i);
		return 64'h0123_4567_0000_0000 | 64'(i);
	endfunction
	function automatic logic [63:0] expv(input int i);
		return (i == 31) ? 64'h0000_0000_0000_0000 : pat(i);
	endfunction
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Back-to-back decodes, then a redirect that also carries a decode
	task t_pc;
		for (int i = 0; i <= 3; i++) begin
			@(posedge clk);
			decode_valid <= (i < 3);
			#1 chk(updated_pc, 64'(4 * i));
		end
		@(posedge clk);
		redirect_valid <= 1'b1;
		decode_valid <= 1'b1;
		redirect_addr <= 64'h0000_0000_0000_1237;
		@(posedge clk);
		redirect_valid <= 1'b0;
		#1 chk(updated_pc, 64'h0000_0000_0000_1234);
		@(posedge clk);
		decode_valid <= 1'b0;
		#1 chk(updated_pc, 64'h0000_0000_0000_1238);
	endtask
	// Write every index with a forwarded read, then read all back
	task t_regs;
		for (int i = 0; i <= 32; i++) begin
			@(posedge clk);
			wr_en <= (i < 32);
			wr_idx <= 5'(i);
			wr_data <= pat(i);
			rd_a_idx <= 5'(i);
			#1 if (i > 0) chk(rd_a_data, expv(i - 1));
		end
		for (int i = 0; i <= 32; i++) begin
			@(posedge clk);
			rd_b_idx <= 5'(i);
			#1 if (i > 0) chk(rd_b_data, expv(i - 1));
		end
		chk(updated_pc, 64'h0000_0000_0000_1238);
	endtask
	// Push across zero must wrap as unsigned, pop returns old pointer
	task t_stack;
		@(posedge clk);
		wr_en <= 1'b1;
		wr_idx <= SP_IDX;
		wr_data <= 64'h0000_0000_0000_0004;
		rd_a_idx <= SP_IDX;
		@(posedge clk);
		wr_en <= 1'b0;
		sp_push <= 1'b1;
		sp_len <= 8'h08;
		@(posedge clk);
		sp_push <= 1'b0;
		sp_pop <= 1'b1;
		#1 chk(sp_addr, 64'hffff_ffff_ffff_fffc);
		@(posedge clk);
		sp_pop <= 1'b0;
		#1 chk(sp_addr, 64'hffff_ffff_ffff_fffc);
		@(posedge clk);
		#1 chk(rd_a_data, 64'h0000_0000_0000_0004);
	endtask
	// Unprivileged calls are dropped; privileged write touches bits 1:0 only
	task t_status;
		@(posedge clk);
		hw_status_load <= 1'b1;
		hw_status_data <= 16'habcd;
		write_status_call <= 1'b1;
		status_sw_data <= 2'h2;
		@(posedge clk);
		hw_status_load <= 1'b0;
		write_status_call <= 1'b0;
		read_status_call <= 1'b1;
		@(posedge clk);
		priv_mode <= 1'b1;
		#1 chk(64'(status_rd_data), 64'h0000_0000_0000_0000);
		@(posedge clk);
		read_status_call <= 1'b0;
		write_status_call <= 1'b1;
		#1 chk(64'(status_rd_data), 64'h0000_0000_0000_abcd);
		@(posedge clk);
		write_status_call <= 1'b0;
		read_status_call <= 1'b1;
		@(posedge clk);
		read_status_call <= 1'b0;
		#1 chk(64'(status_rd_data), 64'h0000_0000_0000_abce);
	endtask
	task cls(input int t, input int k, input logic [2:0] a, input logic m, input logic u);
		@(posedge clk);
		oper_type <= cars_dtype_t'(t);
		oper_kind <= cars_opkind_t'(k);
		oper_addr_low <= a;
		@(posedge clk);
		#1 chk(64'(oper_misaligned), 64'(m));
		chk(64'(oper_unsupported), 64'(u));
	endtask
	// Every type at every low offset, then every operation kind on double-d
	task t_class;
		logic lw;
		for (int t = 0; t < 14; t++) begin
			lw = (t == 0 || t == 2 || t == 5);
			for (int a = 0; a < 8; a++) begin
				cls(t, 0, 3'(a), (t < 7) && (lw ? (a % 4) != 0 : a != 0), t >= 7);
			end
		end
		for (int k = 0; k < 4; k++) begin
			cls(4, k, 3'h0, 1'b0, k == 3);
		end
	endtask
	// Float zero entry reads zero and drops its write enable
	task t_fp;
		for (int i = 30; i <= 32; i++) begin
			@(posedge clk);
			fp_rd_idx <= 5'(i);
			fp_wr_idx <= 5'(i);
			fp_wr_en_in <= 1'b1;
			#1 if (i > 30) chk(fp_rd_data, (i == 32) ? 64'h0000_0000_0000_0000 : 64'h3ff0_0000_0000_001e);
			chk(64'(fp_wr_en_out), 64'(i != 31));
		end
	endtask
	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		#1 chk(sp_addr, 64'h0000_0000_0000_0000);
		t_pc();
		t_regs();
		t_stack();
		t_status();
		t_class();
		t_fp();
		finish_test();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#40000;
		fails++;
		finish_test();
	end
endmodule
`default_nettype wire
